// [csb_core_sfr.sv]
// core special-function registers, return stack, data banking and axi4-lite access
// How it works
// - eight-entry 16-bit return stack, its pointer hidden from software
// - call or interrupt vectoring pushes the program counter
// - return, return_literal and return_from_irq pop the full address
// - push and pop never touch upper_pc_latch
// - stack wraps circularly; ninth push overwrites the first
// - no overflow or underflow flag anywhere
// - direct bank select 00/01/10 picks bank 0/1/2
// - 208 bytes of RAM at 20-7F, A0-EF and 120-13F
// - F0-FF and 170-17F reach shared bytes common to all banks
// - indirect control at 00/80/100, reset zero, bit1 enables post-decrement
// - bit0 enables file_pointer post-increment after indirect access
// - both bits set means no automatic pointer change
// - flag-updating instruction on status: Z, DC, C come from result
// - timeout and powerdown flags are read-only to writes
// - indirect_bank_select picks 000-0FF or 100-1FF indirectly
// - timeout flag cleared by time-out, set by power-up, clear, sleep
// - powerdown flag cleared by sleep, set by power-up or clear
// - zero, nibble carry and top carry flags follow the result
// - enable register at 0B: global bit 7, sources bits 6..3
// - pending register at 0C: bits 6..3, cleared by writing 0
// - core registers mirrored at the same offset in banks 0..2, except 0B and 0C which answer in bank 0 only
// - interrupt request whenever global, source enable and pending set
// - interrupt response clears global enable, pushes, jumps to 0004
// - direct address = bank bits + 7 bits, indirect = bank bit + pointer
`include "csb_params.svh"
`timescale 1ns/1ns
`default_nettype none

module csb_core_sfr (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// core data access
	input wire logic core_acc_valid,
	input wire logic core_acc_we,
	input wire logic [6:0] core_acc_f,
	input wire logic [7:0] core_wdata,
	output logic [7:0] core_rdata,
	// alu flag update
	input wire logic [2:0] core_flag_mask,
	input wire logic [7:0] alu_result,
	input wire logic alu_digit_carry,
	input wire logic alu_carry,
	input wire logic [7:0] core_pc_low,
	// instruction events
	input wire logic call_evt,
	input wire logic ret_evt,
	input wire logic irq_ack,
	input wire logic [15:0] push_addr,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic watchdog_timeout,
	input wire logic [3:0] irq_src_set,
	output logic pc_load,
	output logic [15:0] pc_load_addr,
	output logic irq_req,
	// axi4-lite slave
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [10:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [10:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp
);
	import csb_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************

	// map a data address to a RAM slot; bit 8 of the answer says it hits
	function automatic logic [8:0] ram_slot(input logic [8:0] a);
		logic [8:0] r;
		r = 9'h000;
		if (a >= `CSB_RAM0_LO && a <= `CSB_RAM0_HI) begin
			r = {1'b1, 8'(a - `CSB_RAM0_LO)};
		end else if (a >= `CSB_RAM1_LO && a <= `CSB_RAM1_HI) begin
			r = {1'b1, 8'(a - `CSB_RAM1_LO) + `CSB_RAM1_BASE};
		end else if (a >= `CSB_SHR1_LO && a <= `CSB_SHR1_HI) begin
			r = {1'b1, 8'(a - `CSB_SHR1_LO) + `CSB_SHARED_BASE};
		end else if (a >= `CSB_RAM2_LO && a <= `CSB_RAM2_HI) begin
			r = {1'b1, 8'(a - `CSB_RAM2_LO) + `CSB_RAM2_BASE};
		end else if (a >= `CSB_SHR2_LO && a <= `CSB_SHR2_HI) begin
			r = {1'b1, 8'(a - `CSB_SHR2_LO) + `CSB_SHARED_BASE};
		end
		return r;
	endfunction

	// read one byte of data space; bit 8 of the answer says it is mapped
	function automatic logic [8:0] rd_byte(input csb_state_t s, input logic [8:0] a,
		input logic [7:0] prog_counter_low);
		logic [8:0] r;
		logic [8:0] slot;
		logic bank0;
		r = 9'h000;
		slot = ram_slot(a);
		bank0 = (a[8:7] == 2'b00);
		// mirrored core registers answer in banks 0..2
		if (a[8:7] != 2'b11) begin
			case (a[6:0])
				`CSB_OFF_IND_CTRL: r = {1'b1, s.imc & `CSB_MASK_IND_CTRL};
				`CSB_OFF_PC_LOW: r = {1'b1, prog_counter_low};
				`CSB_OFF_STATUS: r = {1'b1, s.status};
				`CSB_OFF_FILE_PTR: r = {1'b1, s.fp};
				`CSB_OFF_UPPER_PC: r = {1'b1, s.upl};
				`CSB_OFF_IRQ_EN: r = {bank0, bank0 ? (s.ien & `CSB_MASK_IRQ_EN) : 8'h00};
				`CSB_OFF_IRQ_PND: r = {bank0, bank0 ? (s.internal_irq_pending & `CSB_MASK_IRQ_PND) : 8'h00};
				default: r = 9'h000;
			endcase
		end
		if (slot[8]) begin
			r = {1'b1, s.ram[slot[7:0]]};
		end
		return r;
	endfunction

	// write one byte of data space into a state copy
	function automatic csb_state_t wr_byte(input csb_state_t s, input logic [8:0] a,
		input logic [7:0] d);
		csb_state_t r;
		logic [8:0] slot;
		logic bank0;
		r = s;
		slot = ram_slot(a);
		bank0 = (a[8:7] == 2'b00);
		if (a[8:7] != 2'b11) begin
			case (a[6:0])
				`CSB_OFF_IND_CTRL: r.imc = d & `CSB_MASK_IND_CTRL;
				`CSB_OFF_PC_LOW: begin
					// a write to the low counter jumps using the latched upper byte
					r.pc_load = 1'b1;
					r.pc_addr = {s.upl, d};
				end
				`CSB_OFF_STATUS: begin
					// timeout and powerdown keep their value
					r.status = {d[7:5], s.status[`CSB_ST_TO:`CSB_ST_PD], d[2:0]};
				end
				`CSB_OFF_FILE_PTR: r.fp = d;
				`CSB_OFF_UPPER_PC: r.upl = d;
				`CSB_OFF_IRQ_EN: begin
					if (bank0) begin
						r.ien = d & `CSB_MASK_IRQ_EN;
					end
				end
				`CSB_OFF_IRQ_PND: begin
					// a zero clears, a one leaves the bit alone
					if (bank0) begin
						r.internal_irq_pending = s.internal_irq_pending & (d | ~`CSB_MASK_IRQ_PND) & `CSB_MASK_IRQ_PND;
					end
				end
				default: r = r;
			endcase
		end
		if (slot[8]) begin
			r.ram[slot[7:0]] = d;
		end
		return r;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	csb_state_t st_r;
	csb_state_t st_nxt;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;

	// readies drop while the clock enable freezes the state, so nothing is lost
	assign s_axi_awready = clk_en && (st_r.wst == CSB_WS_IDLE || st_r.wst == CSB_WS_DATA);
	assign s_axi_wready = clk_en && (st_r.wst == CSB_WS_IDLE || st_r.wst == CSB_WS_ADDR);
	assign s_axi_arready = clk_en && !st_r.rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;

	// ************************************************************
	// next-state logic
	// ************************************************************
	always_comb begin
		logic [8:0] eff;
		logic [8:0] rd;
		logic [8:0] ard;
		logic indirect;
		st_nxt = st_r;
		eff = 9'h000;
		rd = 9'h000;
		ard = 9'h000;
		indirect = 1'b0;
		st_nxt.pc_load = 1'b0;

		// core access: offset zero means indirect through the file pointer
		indirect = (core_acc_f == `CSB_OFF_IND_CTRL);
		if (indirect) begin
			eff = {st_r.status[`CSB_ST_IBS], st_r.fp};
		end else begin
			eff = {st_r.status[`CSB_ST_RP_HI:`CSB_ST_RP_LO], core_acc_f};
		end
		if (core_acc_valid) begin
			rd = rd_byte(st_r, eff, core_pc_low);
			st_nxt.core_rdata = rd[7:0];
			if (core_acc_we) begin
				// pointer at zero targets the control register itself
				st_nxt = wr_byte(st_nxt, eff, core_wdata);
			end
			// post-modify unless the same access wrote the pointer
			if (indirect && !(core_acc_we && eff[6:0] == `CSB_OFF_FILE_PTR && eff[8:7] != 2'b11)) begin
				if (st_r.imc[`CSB_IMC_INC] && !st_r.imc[`CSB_IMC_DEC]) begin
					st_nxt.fp = st_r.fp + 8'h01;
				end else if (st_r.imc[`CSB_IMC_DEC] && !st_r.imc[`CSB_IMC_INC]) begin
					st_nxt.fp = st_r.fp - 8'h01;
				end
			end
		end

		// alu flags override a core write to the same three bits; an axi write committed in the same cycle overrides them
		if (core_flag_mask[2]) begin
			st_nxt.status[`CSB_ST_Z] = (alu_result == 8'h00);
		end
		if (core_flag_mask[1]) begin
			st_nxt.status[`CSB_ST_DC] = alu_digit_carry;
		end
		if (core_flag_mask[0]) begin
			st_nxt.status[`CSB_ST_C] = alu_carry;
		end

		// axi write channel; the commit waits for a cycle with no core access
		case (st_r.wst)
			CSB_WS_IDLE: begin
				if (aw_hs && w_hs) begin
					st_nxt.wst = CSB_WS_BOTH;
				end else if (aw_hs) begin
					st_nxt.wst = CSB_WS_ADDR;
				end else if (w_hs) begin
					st_nxt.wst = CSB_WS_DATA;
				end
			end
			CSB_WS_ADDR: begin
				if (w_hs) begin
					st_nxt.wst = CSB_WS_BOTH;
				end
			end
			CSB_WS_DATA: begin
				if (aw_hs) begin
					st_nxt.wst = CSB_WS_BOTH;
				end
			end
			CSB_WS_BOTH: begin
				if (!core_acc_valid) begin
					ard = rd_byte(st_r, st_r.aw_idx, core_pc_low);
					if (ard[8] && st_r.wbyte_en) begin
						st_nxt = wr_byte(st_nxt, st_r.aw_idx, st_r.wbyte);
					end
					st_nxt.bresp = ard[8] ? `CSB_AXI_OKAY : `CSB_AXI_SLVERR;
					st_nxt.wst = CSB_WS_RESP;
				end
			end
			CSB_WS_RESP: begin
				if (s_axi_bready) begin
					st_nxt.wst = CSB_WS_IDLE;
				end
			end
			default: st_nxt.wst = CSB_WS_IDLE;
		endcase
		if (aw_hs) begin
			st_nxt.aw_idx = s_axi_awaddr[10:2];
		end
		if (w_hs) begin
			st_nxt.wbyte = s_axi_wdata[7:0];
			st_nxt.wbyte_en = s_axi_wstrb[0];
		end

		// axi read channel, one word at a time
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (ar_hs) begin
			ard = rd_byte(st_r, s_axi_araddr[10:2], core_pc_low);
			st_nxt.rbyte = ard[7:0];
			st_nxt.rresp = ard[8] ? `CSB_AXI_OKAY : `CSB_AXI_SLVERR;
			st_nxt.rvalid = 1'b1;
		end

		// watchdog and sleep events come after writes, so they always win
		if (watchdog_clear_instr) begin
			st_nxt.status[`CSB_ST_TO] = 1'b1;
			st_nxt.status[`CSB_ST_PD] = 1'b1;
		end
		if (sleep_instr) begin
			st_nxt.status[`CSB_ST_TO] = 1'b1;
			st_nxt.status[`CSB_ST_PD] = 1'b0;
		end
		if (watchdog_timeout) begin
			st_nxt.status[`CSB_ST_TO] = 1'b0;
		end

		// a source event in the clearing cycle still sets its pending bit
		st_nxt.internal_irq_pending[`CSB_SRC_MSB:`CSB_SRC_LSB] =
			st_nxt.internal_irq_pending[`CSB_SRC_MSB:`CSB_SRC_LSB] | irq_src_set;

		// return stack; upper_pc_latch is never touched here, no wrap flag exists
		if (irq_ack) begin
			st_nxt.stack[st_r.sp] = push_addr;
			st_nxt.sp = st_r.sp + 3'h1;
			st_nxt.ien[`CSB_IEN_GIE] = 1'b0;
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_addr = `CSB_IRQ_VECTOR;
		end else if (call_evt) begin
			st_nxt.stack[st_r.sp] = push_addr;
			st_nxt.sp = st_r.sp + 3'h1;
		end else if (ret_evt) begin
			st_nxt.sp = st_r.sp - 3'h1;
			st_nxt.pc_load = 1'b1;
			st_nxt.pc_addr = st_r.stack[st_r.sp - 3'h1];
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.wst <= CSB_WS_IDLE;
			st_r.imc <= `CSB_RST_IND_CTRL;
			st_r.status <= `CSB_RST_STATUS;
			st_r.fp <= `CSB_RST_FILE_PTR;
			st_r.upl <= `CSB_RST_UPPER_PC;
			st_r.ien <= `CSB_RST_IRQ_EN;
			st_r.internal_irq_pending <= `CSB_RST_IRQ_PND;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign core_rdata = st_r.core_rdata;
	assign pc_load = st_r.pc_load;
	assign pc_load_addr = st_r.pc_addr;
	assign s_axi_bvalid = (st_r.wst == CSB_WS_RESP);
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = {24'h000000, st_r.rbyte};
	assign s_axi_rresp = st_r.rresp;
	// request stays up as long as global enable is set and any enabled source is pending
	assign irq_req = st_r.ien[`CSB_IEN_GIE] &&
		|(st_r.ien[`CSB_SRC_MSB:`CSB_SRC_LSB] & st_r.internal_irq_pending[`CSB_SRC_MSB:`CSB_SRC_LSB]);

endmodule

`default_nettype wire

// [csb_params.svh]
// constants for the core special-function, stack and banking block
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// ************************************************************
// register offsets inside each bank (low seven address bits)
// ************************************************************
`define CSB_OFF_IND_CTRL 7'h00
`define CSB_OFF_PC_LOW 7'h02
`define CSB_OFF_STATUS 7'h03
`define CSB_OFF_FILE_PTR 7'h04
`define CSB_OFF_UPPER_PC 7'h0a
`define CSB_OFF_IRQ_EN 7'h0b
`define CSB_OFF_IRQ_PND 7'h0c

// ************************************************************
// field positions
// ************************************************************
`define CSB_IMC_INC 0
`define CSB_IMC_DEC 1
`define CSB_ST_C 0
`define CSB_ST_DC 1
`define CSB_ST_Z 2
`define CSB_ST_PD 3
`define CSB_ST_TO 4
`define CSB_ST_RP_LO 5
`define CSB_ST_RP_HI 6
`define CSB_ST_IBS 7
`define CSB_IEN_GIE 7
`define CSB_SRC_LSB 3
`define CSB_SRC_MSB 6

// ************************************************************
// reset values and implemented-bit masks
// ************************************************************
`define CSB_RST_IND_CTRL 8'h00
`define CSB_RST_STATUS 8'h18
`define CSB_RST_FILE_PTR 8'h00
`define CSB_RST_UPPER_PC 8'h00
`define CSB_RST_IRQ_EN 8'h00
`define CSB_RST_IRQ_PND 8'h00
`define CSB_MASK_IND_CTRL 8'h03
`define CSB_MASK_IRQ_EN 8'hf8
`define CSB_MASK_IRQ_PND 8'h78

// ************************************************************
// memory layout and fixed addresses
// ************************************************************
`define CSB_IRQ_VECTOR 16'h0004
`define CSB_RAM_BYTES 208
`define CSB_RAM0_LO 9'h020
`define CSB_RAM0_HI 9'h07f
`define CSB_RAM1_LO 9'h0a0
`define CSB_RAM1_HI 9'h0ef
`define CSB_SHR1_LO 9'h0f0
`define CSB_SHR1_HI 9'h0ff
`define CSB_RAM2_LO 9'h120
`define CSB_RAM2_HI 9'h13f
`define CSB_SHR2_LO 9'h170
`define CSB_SHR2_HI 9'h17f
`define CSB_RAM1_BASE 8'h60
`define CSB_RAM2_BASE 8'hb0
`define CSB_SHARED_BASE 8'h50
`define CSB_AXI_OKAY 2'h0
`define CSB_AXI_SLVERR 2'h2

`endif

// [csb_pkg.sv]
// types of the core special-function, stack and banking block
package csb_pkg;

	// axi write channel states, one-hot
	typedef enum logic [4:0] {
		CSB_WS_IDLE = 5'h01,
		CSB_WS_ADDR = 5'h02,
		CSB_WS_DATA = 5'h04,
		CSB_WS_BOTH = 5'h08,
		CSB_WS_RESP = 5'h10
	} csb_wstate_t;

	// every flip-flop of the block
	typedef struct packed {
		csb_wstate_t wst;
		logic [8:0] aw_idx;
		logic [7:0] wbyte;
		logic wbyte_en;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rbyte;
		logic [1:0] rresp;
		logic [7:0] imc;
		logic [7:0] status;
		logic [7:0] fp;
		logic [7:0] upl;
		logic [7:0] ien;
		logic [7:0] internal_irq_pending;
		logic [2:0] sp;
		logic [7:0][15:0] stack;
		logic [207:0][7:0] ram;
		logic [7:0] core_rdata;
		logic pc_load;
		logic [15:0] pc_addr;
	} csb_state_t;

endpackage

// [csb_core_sfr_asserts.sv]
// assertions for the core special-function, stack and banking block
`timescale 1ns/1ns
`default_nettype none
module csb_core_sfr_asserts (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic call_evt,
	input wire logic ret_evt,
	input wire logic irq_ack,
	input wire logic [15:0] push_addr,
	input wire logic pc_load,
	input wire logic [15:0] pc_load_addr,
	input wire logic irq_req,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	// ****************
	// checks
	// ****************
	// a frozen clock enable holds all state, so checks pause with it
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n || !clk_en);
	// a cycle with no stack event
	sequence quiet;
		!(call_evt || ret_evt || irq_ack);
	endsequence
	AST_PUSH_POP: assert property ((call_evt || irq_ack) ##1 quiet ##1
		(ret_evt && !call_evt && !irq_ack) |=> pc_load && pc_load_addr == $past(push_addr, 3))
		else $error("pop did not return pushed address");
	AST_VECTOR: assert property (irq_ack |=> pc_load && pc_load_addr == 16'h0004)
		else $error("interrupt vector not loaded");
	AST_ACK_MASKS: assert property (irq_ack |=> !irq_req)
		else $error("request still high after response");
	AST_RET_LOADS: assert property (ret_evt && !call_evt && !irq_ack |=> pc_load)
		else $error("return gave no load");
	AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answering");
	AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	COV_ACK: cover property (irq_ack);
	COV_CALL_RET: cover property (call_evt ##2 ret_evt);
	COV_READ: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind csb_core_sfr csb_core_sfr_asserts u_chk (.core_clk, .reset_n, .clk_en, .call_evt,
	.ret_evt, .irq_ack, .push_addr, .pc_load, .pc_load_addr, .irq_req, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

// [csb_core_model.sv]
// behavioural model of the cpu core's instruction event sequencing
`timescale 1ns/1ns
`default_nettype none
module csb_core_model (
	input wire logic core_clk,
	output var logic call_evt,
	output var logic ret_evt,
	output var logic irq_ack,
	output var logic [15:0] push_addr,
	output var logic watchdog_clear_instr,
	output var logic sleep_instr,
	output var logic watchdog_timeout,
	output var logic [3:0] irq_src_set
);
	// ****************
	// event driver
	// ****************
	initial begin
		{call_evt, ret_evt, irq_ack, watchdog_clear_instr} = 4'h0;
		{sleep_instr, watchdog_timeout, irq_src_set} = 6'h00;
		push_addr = 16'h0000;
	end
	// one event word for one cycle; the address then toggles so a stale value is not trusted
	task fire(input logic [9:0] v, input logic [15:0] a);
		@(posedge core_clk);
		{call_evt, ret_evt, irq_ack, watchdog_clear_instr, sleep_instr, watchdog_timeout,
			irq_src_set} <= v;
		push_addr <= a;
		@(posedge core_clk);
		{call_evt, ret_evt, irq_ack, watchdog_clear_instr, sleep_instr, watchdog_timeout,
			irq_src_set} <= 10'h000;
		push_addr <= ~a;
	endtask
endmodule
`default_nettype wire

// [core_sfr_stack_banking_tb_top.sv]
// self-checking testbench of the core special-function, stack and banking block
`timescale 1ns/1ns
`default_nettype none
module core_sfr_stack_banking_tb_top;
	logic core_clk, reset_n, clk_en, core_acc_valid, core_acc_we, alu_digit_carry, alu_carry;
	logic [6:0] core_acc_f;
	logic [7:0] core_wdata, core_rdata, alu_result, core_pc_low, rv;
	logic [2:0] core_flag_mask;
	logic call_evt, ret_evt, irq_ack, watchdog_clear_instr, sleep_instr, watchdog_timeout;
	logic pc_load, irq_req, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [15:0] push_addr, pc_load_addr;
	logic [3:0] irq_src_set, s_axi_wstrb;
	logic [10:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	int bad_count, checks_done;

	csb_core_sfr DUT (.core_clk, .reset_n, .clk_en, .core_acc_valid, .core_acc_we,
		.core_acc_f, .core_wdata, .core_rdata, .core_flag_mask, .alu_result,
		.alu_digit_carry, .alu_carry, .core_pc_low, .call_evt, .ret_evt, .irq_ack,
		.push_addr, .watchdog_clear_instr, .sleep_instr, .watchdog_timeout, .irq_src_set,
		.pc_load, .pc_load_addr, .irq_req, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
	csb_core_model m (.core_clk, .call_evt, .ret_evt, .irq_ack, .push_addr,
		.watchdog_clear_instr, .sleep_instr, .watchdog_timeout, .irq_src_set);

	// ****************
	// helpers
	// ****************
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// bus write; address and data offered together, each released once taken
	task wr(input logic [8:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		s_axi_awaddr <= {a, 2'b00};
		s_axi_wdata <= {24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		s_axi_bready <= 1'b0;
		rr = s_axi_bresp;
		if (!s_axi_bvalid) begin
			bad_count++;
			tally_and_finish;
		end
	endtask
	task rd(input logic [8:0] a, output logic [7:0] d);
		int n;
		@(posedge core_clk);
		s_axi_araddr <= {a, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata[7:0];
		rr = s_axi_rresp;
		if (!s_axi_rvalid) begin
			bad_count++;
			tally_and_finish;
		end
	endtask
	// one core data access, optionally with a flag update in the same cycle
	task cacc(input logic we, input logic [6:0] f, input logic [7:0] d, input logic [2:0] fm);
		@(posedge core_clk);
		{core_acc_valid, core_acc_we, core_acc_f, core_wdata, core_flag_mask} <= {1'b1, we, f, d, fm};
		@(posedge core_clk);
		{core_acc_valid, core_flag_mask, core_wdata} <= {1'b0, 3'h0, ~d};
		#1;
	endtask

	// ****************
	// scenarios
	// ****************
	task t_reset;
		rd(9'h000, rv); chk(rv, 8'h00);
		rd(9'h003, rv); chk(rv, 8'h18);
		rd(9'h00b, rv); chk(rv, 8'h00);
		rd(9'h00c, rv); chk(rv, 8'h00);
		rd(9'h180, rv); chk({rr, rv}, 10'h200);
		wr(9'h180, 8'h11); chk(rr, 2'h2);
	endtask
	// nine pushes wrap onto the first slot, then nine pops
	task t_stack;
		wr(9'h00a, 8'h03); chk(rr, 2'h0);
		for (int i = 0; i < 9; i++) m.fire(10'h200, 16'h1000 + 16'(i));
		for (int i = 0; i < 9; i++) begin
			m.fire(10'h100, 16'h0);
			#1;
			chk({pc_load, pc_load_addr}, {1'b1, 16'h1000 + 16'(i < 8 ? 8 - i : 8)});
		end
		rd(9'h00a, rv); chk(rv, 8'h03);
		rd(9'h003, rv); chk(rv, 8'h18);
		// a core write of the low counter jumps with the latched upper byte
		cacc(1'b1, 7'h02, 8'h9c, 3'h0);
		chk({pc_load, pc_load_addr}, {1'b1, 16'h039c});
	endtask
	task t_irq;
		wr(9'h00b, 8'hff);
		rd(9'h00b, rv); chk(rv, 8'hf8);
		m.fire(10'h002, 16'h0);
		#1;
		chk(irq_req, 1'b1);
		rd(9'h00c, rv); chk(rv, 8'h10);
		m.fire(10'h080, 16'h0345);
		#1;
		chk(pc_load_addr, 16'h0004);
		chk(irq_req, 1'b0);
		rd(9'h00b, rv); chk(rv, 8'h78);
		m.fire(10'h100, 16'h0);
		#1;
		chk(pc_load_addr, 16'h0345);
		wr(9'h00c, 8'h00);
		rd(9'h00c, rv); chk(rv, 8'h00);
	endtask
	task t_status;
		wr(9'h003, 8'h00);
		rd(9'h003, rv); chk(rv, 8'h18);
		m.fire(10'h020, 16'h0);
		rd(9'h003, rv); chk(rv, 8'h10);
		m.fire(10'h010, 16'h0);
		rd(9'h003, rv); chk(rv, 8'h00);
		m.fire(10'h040, 16'h0);
		rd(9'h003, rv); chk(rv, 8'h18);
		cacc(1'b1, 7'h03, 8'h27, 3'h7);
		rd(9'h003, rv); chk(rv, 8'h39);
		cacc(1'b1, 7'h20, 8'hb1, 3'h0);
		@(posedge core_clk);
		{alu_result, alu_digit_carry, alu_carry} <= 10'h002;
		cacc(1'b0, 7'h20, 8'h00, 3'h7);
		chk(core_rdata, 8'hb1);
		rd(9'h0a0, rv); chk(rv, 8'hb1);
		rd(9'h083, rv); chk(rv, 8'h3e);
		rd(9'h102, rv); chk(rv, 8'h5a);
		cacc(1'b1, 7'h75, 8'hc3, 3'h0);
		rd(9'h075, rv); chk(rv, 8'hc3);
		// a sleep event while the clock enable is low must leave the flags alone
		@(posedge core_clk);
		clk_en <= 1'b0;
		m.fire(10'h020, 16'h0);
		clk_en <= 1'b1;
		rd(9'h003, rv); chk(rv, 8'h3e);
	endtask
	task t_indirect;
		wr(9'h004, 8'h21);
		wr(9'h000, 8'h01);
		cacc(1'b1, 7'h00, 8'h44, 3'h0);
		rd(9'h004, rv); chk(rv, 8'h22);
		rd(9'h021, rv); chk(rv, 8'h44);
		wr(9'h000, 8'h02);
		cacc(1'b0, 7'h00, 8'h00, 3'h0);
		rd(9'h004, rv); chk(rv, 8'h21);
		wr(9'h000, 8'hff);
		rd(9'h000, rv); chk(rv, 8'h03);
		wr(9'h003, 8'h80);
		cacc(1'b1, 7'h00, 8'h55, 3'h0);
		rd(9'h004, rv); chk(rv, 8'h21);
		rd(9'h121, rv); chk(rv, 8'h55);
		// software path to the control register: clear the pointer, then go indirect
		wr(9'h003, 8'h00);
		cacc(1'b1, 7'h04, 8'h00, 3'h0);
		cacc(1'b1, 7'h00, 8'h01, 3'h0);
		rd(9'h000, rv); chk(rv, 8'h01);
	endtask

	initial begin
		{reset_n, clk_en, core_acc_valid, core_acc_we, core_acc_f, core_wdata} = 19'h20000;
		{core_flag_mask, alu_result, alu_digit_carry, alu_carry} = 13'h005;
		{core_pc_low, s_axi_wstrb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = {8'h5a, 4'h1, 54'h0};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{bad_count, checks_done} = 64'h0;
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		t_reset;
		t_stack;
		t_irq;
		t_status;
		t_indirect;
		tally_and_finish;
	end
	// cuts a hang short
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
